// ===== verilog/spi_frame_command_decoder.sv
// Purpose: decode 16-bit spi command frames and pick the next reply
// Assumes: link pins sampled by CLOCK, spi mode 1, apb slave access
// Notes:   reply to a frame leaves during the following frame
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
module spi_frame_command_decoder #(
    parameter logic [7:0] IDENT_VALUE = 8'h5a,  // arbitrary value
    parameter int         CNT_W       = 16
) (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    // serial link
    input  wire logic        SCLK,
    input  wire logic        CSN,
    input  wire logic        SI,
    output logic             SO,
    output logic             SO_OE,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // interrupt
    output logic             IRQ
);
    localparam int NE = spi_cmd_pkg::NUM_EVENTS;

    // pin synchronisers, three stages each
    logic [2:0] sclk_s_q;
    logic [2:0] csn_s_q;
    logic [2:0] si_s_q;
    logic       sclk_f_q;       // filtered serial clock
    logic       csn_f_q;        // filtered chip select

    // link state
    spi_cmd_pkg::link_state_type state_q;
    logic [15:0]      rx_q;     // received word
    logic [15:0]      tx_q;     // outgoing word
    logic [CNT_W-1:0] cnt_q;    // clocks in this frame
    logic [15:0]      reply_q;  // reply for next frame
    logic             so_q;     // serial output bit

    // registers
    logic [15:0]   diag_src_q;  // diagnosis source fields
    logic [15:0]   last_cmd_q;  // last accepted frame
    logic [NE-1:0] irq_st_q;    // sticky events
    logic [NE-1:0] irq_en_q;    // event enables
    logic          soft_q;      // soft reset strobe
    logic [31:0]   prdata_q;    // read data
    // slave error is decoded straight from the access phase

    // edge detection on agreed samples
    wire sclk_agree = (sclk_s_q[1] == sclk_s_q[2]);
    wire csn_agree  = (csn_s_q[1] == csn_s_q[2]);
    wire sclk_fall  = sclk_agree && sclk_f_q && !sclk_s_q[2];
    wire csn_fall   = csn_agree && csn_f_q && !csn_s_q[2];
    wire csn_rise   = csn_agree && !csn_f_q && csn_s_q[2];
    wire si_bit     = si_s_q[2];

    // frame decode at chip select rise
    spi_cmd_pkg::frame_type fr;
    assign fr = spi_cmd_pkg::frame_type'(rx_q);

    wire len_good  = spi_cmd_pkg::len_ok(16'(cnt_q));
    wire adr_good  = spi_cmd_pkg::addr_ok(fr.primary_address_field,
                                          fr.secondary_address_field);
    wire is_diag   = !rx_q[15] && fr.data[1:0] == spi_cmd_pkg::TAIL_DIAG;
    wire is_read   = fr.op == spi_cmd_pkg::OP_READ
                     && fr.data[1:0] == spi_cmd_pkg::TAIL_READ;
    wire is_write  = fr.op == spi_cmd_pkg::OP_WRITE;
    wire read_ok   = is_read && adr_good;
    wire write_ok  = is_write && adr_good;
    // anything not recognised is a syntax error
    wire syntax    = !is_diag && !read_ok && !write_ok;
    wire frame_end = (state_q == spi_cmd_pkg::LINK_SHIFT) && csn_rise;
    wire accept    = frame_end && len_good;
    wire bad_len   = frame_end && !len_good;

    // register bank access
    spi_cmd_pkg::bank_wr_type bank_wr;
    logic [7:0]               bank_rd;
    assign bank_wr.en = accept && write_ok && !is_diag;
    assign bank_wr.primary_address_field   = fr.primary_address_field;
    assign bank_wr.secondary_address_field = fr.secondary_address_field;
    assign bank_wr.data                    = fr.data;

    register_bank #(
        .PRIMARY_W   (4),
        .SECONDARY_W (2)
    ) u_bank (
        .clock   (CLOCK),
        .nrst    (NRST),
        .clear   (soft_q),
        .wr      (bank_wr),
        .rd_pa   (fr.primary_address_field),
        .rd_sa   (fr.secondary_address_field),
        .rd_data (bank_rd)
    );

    // diagnosis word, top bit zero, error flag inserted
    wire [15:0] diag_word = {1'b0, diag_src_q[14:11], !len_good,
                             diag_src_q[9:0]};
    // reset response: error flag set with identification
    wire [15:0] rst_word  = {1'b0, diag_src_q[14:11], 1'b1,
                             diag_src_q[9:8], IDENT_VALUE};
    // read reply echoes both address fields
    wire [15:0] read_word = {spi_cmd_pkg::OP_WRITE,
                             fr.primary_address_field,
                             fr.secondary_address_field,
                             bank_rd};

    // reply chosen for the next frame
    wire [15:0] next_reply = (len_good && !is_diag && read_ok) ?
                             read_word : diag_word;

    // apb decode
    wire apb_wr   = PSEL && PENABLE && PWRITE;
    wire apb_rd   = PSEL && PENABLE && !PWRITE;
    wire a_ctrl   = PADDR == spi_cmd_pkg::OFS_CTRL;
    wire a_diag   = PADDR == spi_cmd_pkg::OFS_DIAG_SRC;
    wire a_last   = PADDR == spi_cmd_pkg::OFS_LAST_CMD;
    wire a_ist    = PADDR == spi_cmd_pkg::OFS_IRQ_STATUS;
    wire a_ien    = PADDR == spi_cmd_pkg::OFS_IRQ_ENABLE;
    wire a_iclr   = PADDR == spi_cmd_pkg::OFS_IRQ_CLEAR;
    wire a_map    = a_ctrl | a_diag | a_last | a_ist | a_ien | a_iclr;
    wire soft_req = apb_wr && a_ctrl && PWDATA[spi_cmd_pkg::SOFT_RST];

    // read mux
    wire [31:0] rd_mux = a_diag ? {16'h0000, diag_src_q} :
                         a_last ? {16'h0000, last_cmd_q} :
                         a_ist  ? 32'(irq_st_q) :
                         a_ien  ? 32'(irq_en_q) : 32'h0000_0000;

    // events of this cycle
    wire [NE-1:0] ev;
    assign ev[spi_cmd_pkg::EV_FRAME]  = accept;
    assign ev[spi_cmd_pkg::EV_LEN_ERR] = bad_len;
    assign ev[spi_cmd_pkg::EV_SYNTAX] = accept && syntax;
    assign ev[spi_cmd_pkg::EV_WRITE]  = bank_wr.en;

    wire [NE-1:0] clr = (apb_wr && a_iclr) ? PWDATA[NE-1:0] : '0;

    // zero wait apb answer
    assign PREADY  = 1'b1;
    assign PRDATA  = prdata_q;
    assign PSLVERR = PSEL && PENABLE && !a_map;
    assign IRQ     = |(irq_st_q & irq_en_q);
    // driven only inside a frame
    assign SO      = so_q;
    assign SO_OE   = (state_q == spi_cmd_pkg::LINK_SHIFT);

    // pin synchronisers
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            sclk_s_q <= 3'h0;
            csn_s_q  <= 3'h7;
            si_s_q   <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], SCLK};
            csn_s_q  <= {csn_s_q[1:0], CSN};
            si_s_q   <= {si_s_q[1:0], SI};
        end
    end

    // filtered levels follow once two stages agree
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            sclk_f_q <= 1'b0;
            csn_f_q  <= 1'b1;
        end else begin
            if (sclk_agree) sclk_f_q <= sclk_s_q[2];
            if (csn_agree)  csn_f_q  <= csn_s_q[2];
        end
    end

    // link state machine
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            state_q <= spi_cmd_pkg::LINK_IDLE;
        end else begin
            case (state_q)
                spi_cmd_pkg::LINK_IDLE: begin
                    if (csn_fall) state_q <= spi_cmd_pkg::LINK_SHIFT;
                end
                spi_cmd_pkg::LINK_SHIFT: begin
                    if (csn_rise) state_q <= spi_cmd_pkg::LINK_IDLE;
                end
                default: state_q <= spi_cmd_pkg::LINK_IDLE;
            endcase
        end
    end

    // shifter: load reply at frame start, shift on falling clock
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            tx_q  <= 16'h0000;
            rx_q  <= 16'h0000;
            cnt_q <= '0;
            so_q  <= 1'b0;
        end else if (csn_fall && state_q == spi_cmd_pkg::LINK_IDLE) begin
            tx_q  <= reply_q;
            so_q  <= reply_q[15];
            cnt_q <= '0;
        end else if (sclk_fall && state_q == spi_cmd_pkg::LINK_SHIFT) begin
            rx_q  <= {rx_q[14:0], si_bit};
            tx_q  <= {tx_q[14:0], si_bit};       // chain passthrough
            so_q  <= tx_q[14];
            if (~&cnt_q) cnt_q <= cnt_q + 1'b1;  // saturating
        end
    end

    // reply for the following frame
    always_ff @(posedge CLOCK) begin
        if (!NRST || soft_q) begin
            reply_q <= rst_word;
        end else if (frame_end) begin
            reply_q <= next_reply;
        end
    end

    // last accepted command for software
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            last_cmd_q <= spi_cmd_pkg::RST_LAST_CMD;
        end else if (accept) begin
            last_cmd_q <= rx_q;
        end
    end

    // software registers
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            diag_src_q <= spi_cmd_pkg::RST_DIAG_SRC;
            irq_en_q   <= spi_cmd_pkg::RST_IRQ_EN;
            soft_q     <= 1'b0;
        end else begin
            soft_q <= soft_req;
            if (apb_wr && a_diag) diag_src_q <= PWDATA[15:0];
            if (apb_wr && a_ien)  irq_en_q   <= PWDATA[NE-1:0];
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~clr) | ev;
        end
    end

    // registered read data
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            // capture in setup so data stands for the whole access
            if (PSEL && !PENABLE && !PWRITE) prdata_q <= rd_mux;
            else if (apb_rd)                 prdata_q <= prdata_q;
        end
    end
endmodule : spi_frame_command_decoder

// ===== inc/spi_cmd_pkg.sv
// Purpose: shared constants and types of the spi command decoder
// Assumes: 16-bit command frames, apb register access
// Notes:   register bank addresses are primary/secondary pairs
package spi_cmd_pkg;

    // apb byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_DIAG_SRC   = 8'h04;
    localparam logic [7:0] OFS_LAST_CMD   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;

    // reset values
    localparam logic [15:0] RST_DIAG_SRC  = 16'h7800;
    localparam logic [3:0]  RST_IRQ_EN    = 4'h0;
    localparam logic [15:0] RST_LAST_CMD  = 16'h0000;
    localparam logic [7:0]  RST_BANK      = 8'h00;

    // field positions
    localparam int ERR_FLAG_BIT = 10;
    localparam int SOFT_RST    = 0;
    localparam int EV_FRAME    = 0;
    localparam int EV_LEN_ERR  = 1;
    localparam int EV_SYNTAX   = 2;
    localparam int EV_WRITE    = 3;
    localparam int NUM_EVENTS  = 4;

    // frame length figures in serial clocks
    localparam int FRAME_MIN   = 16;
    localparam int FRAME_STEP  = 8;

    // leading two bits of a frame
    localparam logic [1:0] OP_READ  = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    // trailing two bits
    localparam logic [1:0] TAIL_DIAG = 2'h1;
    localparam logic [1:0] TAIL_READ = 2'h2;

    // highest primary address that is implemented
    localparam logic [3:0] PRIMARY_LAST = 4'h9;

    // command frame overlay
    typedef struct packed {
        logic [1:0] op;
        logic [3:0] primary_address_field;
        logic [1:0] secondary_address_field;
        logic [7:0] data;
    } frame_type;

    // bank write request
    typedef struct packed {
        logic       en;
        logic [3:0] primary_address_field;
        logic [1:0] secondary_address_field;
        logic [7:0] data;
    } bank_wr_type;

    // link phase
    typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_type;

    // implemented register address
    function automatic logic addr_ok(input logic [3:0] pa,
                                     input logic [1:0] sa);
        addr_ok = (pa <= PRIMARY_LAST) && (sa != 2'h3);
    endfunction : addr_ok

    // 16 plus a multiple of 8 clocks
    function automatic logic len_ok(input logic [15:0] n);
        len_ok = (n >= 16'(FRAME_MIN)) && (n[2:0] == 3'h0);
    endfunction : len_ok

endpackage : spi_cmd_pkg

// ===== verilog/register_bank.sv
// Purpose: 8-bit configuration registers written over the serial link
// Assumes: caller only writes implemented addresses
// Notes:   soft clear returns every register to its reset value
`timescale 1ns/10ps
module register_bank #(
    parameter int PRIMARY_W   = 4,
    parameter int SECONDARY_W = 2
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      nrst,
    input  wire logic                      clear,
    // write port
    input  wire spi_cmd_pkg::bank_wr_type  wr,
    // read port
    input  wire logic [PRIMARY_W-1:0]      rd_pa,
    input  wire logic [SECONDARY_W-1:0]    rd_sa,
    output logic      [7:0]                rd_data
);
    localparam int DEPTH = 1 << (PRIMARY_W + SECONDARY_W);

    logic [7:0] mem_q [DEPTH];   // register contents

    // read selection
    assign rd_data = mem_q[{rd_pa, rd_sa}];

    // write or clear
    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!nrst || clear) begin
                mem_q[i] <= spi_cmd_pkg::RST_BANK;
            end else if (wr.en && i == int'({wr.primary_address_field,
                                          wr.secondary_address_field}))
            begin
                mem_q[i] <= wr.data;
            end
        end
    end
endmodule : register_bank

// ===== dv/spi_frame_command_decoder_asserts.sv
// Purpose: port checks of the spi command decoder
// Assumes: one CLOCK domain, NRST synchronous active low
// Notes:   bound onto the design top below
`timescale 1ns/10ps
module spi_frame_command_decoder_asserts (
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // serial link
    input wire logic SCLK,
    input wire logic CSN,
    input wire logic SO,
    input wire logic SO_OE,
    // apb and interrupt
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    // every check lives in the system clock domain
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // driver turns on soon after select falls
    a_oe_after_select: assert property ($fell(CSN) |-> ##[2:8] SO_OE)
        else $error("so not driven after select");
    // driver turns off soon after select rises
    a_oe_after_release: assert property ($rose(CSN) |-> ##[2:8] !SO_OE)
        else $error("so still driven after release");
    // long idle select means released output
    a_idle_tristate: assert property (CSN [*8] |-> !SO_OE)
        else $error("so driven while idle");
    // long active select means driven output
    a_drive_in_frame: assert property ((!CSN) [*8] |-> SO_OE)
        else $error("so released inside a frame");
    // reply bits move only while the serial clock is low
    a_so_moves_low: assert property
        (SO_OE && $past(SO_OE) && $changed(SO) |-> !SCLK)
        else $error("so moved while serial clock high");
    // events appear only once the frame has closed
    a_act_after_frame: assert property ($rose(IRQ) |->
        $past(PSEL && PENABLE && PWRITE) || (CSN && $past(CSN, 2)))
        else $error("event raised inside a frame");
    // zero wait access phase
    a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase not ready");
    // error reported in access phase only
    a_err_access_only: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("slave error outside access phase");

    // main scenarios reached
    c_frame_end: cover property ($rose(CSN));
    c_slave_err: cover property (PSLVERR);
    c_irq_rise:  cover property ($rose(IRQ));
endmodule : spi_frame_command_decoder_asserts

bind spi_frame_command_decoder spi_frame_command_decoder_asserts u_chk (
    .CLOCK(CLOCK), .NRST(NRST), .SCLK(SCLK), .CSN(CSN), .SO(SO),
    .SO_OE(SO_OE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

// ===== dv/spi_master_model.sv
// Purpose: spi mode 1 master standing at the far end of the link
// Assumes: 160 ns serial clock, lines idle at their pull levels
// Notes:   hands back the first 16 bits seen on the so line
`timescale 1ns/10ps
module spi_master_model (
    // serial link
    output logic      sclk,
    output logic      csn,
    output logic      si,
    input  wire logic so_line
);
    // idle levels of the pulled lines
    initial begin
        sclk = 1'b0;
        csn  = 1'b1;
        si   = 1'b0;
    end

    // one frame of n clocks, msb first, padding ahead of the command
    task automatic xfer(input int n, input logic [15:0] cmd,
                        output logic [15:0] rsp);
        rsp = '0;
        csn = 1'b0;
        #300;
        for (int i = n - 1; i >= 0; i--) begin
            // data set on the rise, held across the fall
            si   = (i < 16) ? cmd[i[3:0]] : 1'b0;
            sclk = 1'b1;
            #80;
            // reply bit read just before the fall
            if (n - 1 - i < 16) rsp = {rsp[14:0], so_line};
            sclk = 1'b0;
            #80;
        end
        #220;
        // raising select hands the frame over
        csn = 1'b1;
        si  = 1'b0;
        #400;
    endtask : xfer
endmodule : spi_master_model

// ===== dv/spi_frame_command_decoder_tb_top.sv
// Purpose: self-checking bench of the spi command decoder
// Assumes: 100 MHz CLOCK, mode 1 master model on the link
// Notes:   each frame of 16 clocks or more is checked against the reply it brings back
`timescale 1ns/10ps
module spi_frame_command_decoder_tb_top;
    // bench state
    logic        clock;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        so;
    logic        so_oe;
    wire         sclk;
    wire         csn;
    wire         si;
    wire         so_line;
    logic [31:0] rd;
    logic        er;
    int          num_errors;
    int          cmp_count;
    // arbitrary identification value
    localparam logic [7:0]  IDENT   = 8'h5a;
    // replies built from the reset diagnosis source
    localparam logic [15:0] DG_OK   = 16'h7800;
    localparam logic [15:0] DG_ERR  = 16'h7c00;
    localparam logic [15:0] RST_RSP = {8'h7c, IDENT};

    // released so line floats
    assign so_line = so_oe ? so : 1'bz;
    always #5 clock = ~clock;

    spi_frame_command_decoder #(.IDENT_VALUE(IDENT), .CNT_W(16)) dut (
        .CLOCK(clock), .NRST(nrst), .SCLK(sclk), .CSN(csn), .SI(si),
        .SO(so), .SO_OE(so_oe), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    spi_master_model u_mst (
        .sclk(sclk), .csn(csn), .si(si), .so_line(so_line));

    // one counted compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // read and compare data and error flag
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask : rdc

    // frame whose reply answers the previous command
    task automatic xf(input int n, input logic [15:0] c,
                      input logic [15:0] e);
        logic [15:0] r;
        u_mst.xfer(n, c, r);
        if (n >= 16) chk({16'h0, r}, {16'h0, e});
    endtask : xf

    // verdict and end of run
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // hang guard
    initial begin
        #300000;
        num_errors++;
        test_done();
    end

    // main sequence
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        rdc(spi_cmd_pkg::OFS_DIAG_SRC, 32'h7800, 1'b0);
        rdc(spi_cmd_pkg::OFS_IRQ_ENABLE, 32'h0, 1'b0);
        rdc(8'h18, 32'h0, 1'b1);
        xf(16, 16'h84a5, RST_RSP);
        xf(16, 16'h4402, DG_OK);
        xf(16, 16'h0001, 16'h84a5);
        xf(16, 16'hc4ff, DG_OK);
        xf(16, 16'h0402, DG_OK);
        xf(16, 16'h6802, DG_OK);
        xf(16, 16'h8700, DG_OK);
        xf(16, 16'h4402, DG_OK);
        xf(12, 16'h0001, 16'h84a5);
        xf(16, 16'h4402, DG_ERR);
        xf(24, 16'h0001, 16'h84a5);
        xf(16, 16'h0001, DG_OK);
        xf(8, 16'h0001, DG_OK);
        xf(16, 16'h0001, DG_ERR);
        xf(17, 16'h0001, DG_OK);
        xf(16, 16'h0001, DG_ERR);
        rdc(spi_cmd_pkg::OFS_LAST_CMD, 32'h1, 1'b0);
        rdc(spi_cmd_pkg::OFS_CTRL, 32'h0, 1'b0);
        rdc(spi_cmd_pkg::OFS_IRQ_STATUS, 32'hf, 1'b0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, spi_cmd_pkg::OFS_IRQ_ENABLE, 32'h4);
        @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, spi_cmd_pkg::OFS_IRQ_CLEAR, 32'h4);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rdc(spi_cmd_pkg::OFS_IRQ_STATUS, 32'hb, 1'b0);
        xf(16, 16'hc000, DG_OK);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, spi_cmd_pkg::OFS_CTRL, 32'h1);
        xf(16, 16'h0001, RST_RSP);
        test_done();
    end
endmodule : spi_frame_command_decoder_tb_top
